// ==== include/lfb_pkg.sv ====
// lfb_pkg: constants and types of the lcd frame and boost clock select block
// assumes: high clock is ref_clk, low clock arrives on a pin and is sampled
package lfb_pkg;
	// clock figure
	localparam int CLK_PERIOD_NS = 8;
	// register offsets on the plain port
	localparam logic [7:0] OFS_LCD_CONTROL = 8'h28;
	localparam logic [7:0] OFS_CLOCK_MODE = 8'h29;
	localparam logic [7:0] OFS_STATUS = 8'h2A;
	// reset values
	localparam logic [7:0] RST_LCD_CONTROL = 8'h00;
	localparam logic [1:0] RST_CLOCK_MODE = 2'h0;
	// clock mode field positions
	localparam int POS_PRESCALER_SOURCE = 0;
	localparam int POS_SYSTEM_CLOCK = 1;
	// status field positions
	localparam int POS_ST_FRAME_LEVEL = 0;
	localparam int POS_ST_BOOST_LEVEL = 1;
	localparam int POS_ST_FRAME_LOW = 2;
	localparam int POS_ST_BIAS_FAULT = 3;
	localparam int POS_ST_FRAME_IDLE = 4;
	localparam int POS_ST_BOOST_IDLE = 5;
	// prescaler widths
	localparam int HIGH_PRE_W = 17;
	localparam int LOW_PRE_W = 9;
	// base divider exponents on the high clock, codes 00..11
	localparam int FRAME_EXP_HIGH_0 = 17;
	localparam int FRAME_EXP_HIGH_1 = 16;
	localparam int FRAME_EXP_HIGH_2 = 15;
	localparam int FRAME_EXP_HIGH_3 = 13;
	// base divider exponents on the low clock, codes 00 and 01
	localparam int FRAME_EXP_LOW_0 = 9;
	localparam int FRAME_EXP_LOW_1 = 8;
	// boost divider exponents on the high clock, codes 00..11
	localparam int BOOST_EXP_HIGH_0 = 13;
	localparam int BOOST_EXP_HIGH_1 = 11;
	localparam int BOOST_EXP_HIGH_2 = 10;
	localparam int BOOST_EXP_HIGH_3 = 9;
	// boost divider exponents on the low clock, codes 00..10
	localparam int BOOST_EXP_LOW_0 = 5;
	localparam int BOOST_EXP_LOW_1 = 3;
	localparam int BOOST_EXP_LOW_2 = 2;
	// fast tick runs at four times base; frame divides it down
	localparam int FAST_SHIFT = 2;
	localparam logic [1:0] FRAME_DIV_QUARTER = 2'h3;
	localparam logic [1:0] FRAME_DIV_THIRD = 2'h2;
	localparam logic [1:0] FRAME_DIV_HALF = 2'h1;
	// duty codes
	typedef enum logic [1:0] {
		DUTY_QUARTER = 2'b00,
		DUTY_THIRD = 2'b01,
		DUTY_HALF = 2'b10,
		DUTY_STATIC = 2'b11
	} lfb_duty_t;
	// control register layout, msb first
	typedef struct packed {
		logic displayEnable;
		logic boosterEnable;
		logic [1:0] boostFreqSelect;
		lfb_duty_t duty;
		logic [1:0] frameRateSelect;
	} lfb_ctrl_t;
	// decoded drive method
	typedef struct packed {
		logic [2:0] commonCount;
		logic biasHalf;
		logic staticDrive;
	} lfb_drive_t;
endpackage : lfb_pkg

// ==== hdl/lfb_clock_select.sv ====
// lfb_clock_select: lcd base/frame clock and booster clock selection
// assumes: ref_clk is the high clock at 125 MHz, lowClock is an unsynchronised pin
// assumes: software avoids the booster and slow-mode codes that status only flags
//
// Summary of operation
// - high clock base divides by 2^17/16/15/13
// - low clock base divides by 2^9/2^8
// - frame is base, 4/3 or twice base
// - booster bit picks booster or resistor divider
// - boost clock from high or low taps
// - duty code selects commons and bias
`timescale 1ns/1ns
module lfb_clock_select (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic lowClock,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	output logic baseTick,
	output logic frameTick,
	output logic boostClk,
	output logic boosterOn,
	output logic dividerOn,
	output logic displayOn,
	output lfb_pkg::lfb_drive_t drive
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// true when the low k bits of a prescaler are all ones
	function automatic logic tapHit(input logic [16:0] cnt, input logic [4:0] k);
		logic hit;
		hit = 1'b1;
		for (int i = 0; i < 17; i++) begin
			if (i < int'(k)) begin
				hit = hit & cnt[i];
			end
		end
		return hit;
	endfunction : tapHit

	// shorten an exponent constant to a tap index
	function automatic logic [4:0] expo(input int e);
		return e[4:0];
	endfunction : expo

	////////////////////////////////////////////////////////////////////////
	// registers

	lfb_pkg::lfb_ctrl_t ctrl_q, ctrl_d;
	logic [1:0] mode_q, mode_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] statusWord;

	// software writes and read return
	always_comb begin
		ctrl_d = ctrl_q;
		mode_d = mode_q;
		rdata_d = 8'h00;
		if (regWrite && regAddr == lfb_pkg::OFS_LCD_CONTROL) begin
			ctrl_d = lfb_pkg::lfb_ctrl_t'(regWdata);
		end
		if (regWrite && regAddr == lfb_pkg::OFS_CLOCK_MODE) begin
			mode_d = regWdata[1:0];
		end
		if (regRead) begin
			case (regAddr)
				lfb_pkg::OFS_LCD_CONTROL: rdata_d = ctrl_q;
				lfb_pkg::OFS_CLOCK_MODE: rdata_d = {6'h00, mode_q};
				lfb_pkg::OFS_STATUS: rdata_d = statusWord;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// register state, synchronous reset
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ctrl_q <= lfb_pkg::lfb_ctrl_t'(lfb_pkg::RST_LCD_CONTROL);
			mode_q <= lfb_pkg::RST_CLOCK_MODE;
			rdata_q <= 8'h00;
		end else begin
			ctrl_q <= ctrl_d;
			mode_q <= mode_d;
			rdata_q <= rdata_d;
		end
	end

	// read data stands one cycle, zero otherwise
	assign regRdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// low clock pin sampling

	logic lowS1_q, lowS2_q, lowS3_q, lowLevel_q, lowLevel_d;
	logic lowEdge;

	// a change counts once stages two and three agree
	always_comb begin
		lowLevel_d = lowLevel_q;
		if (lowS2_q == lowS3_q) begin
			lowLevel_d = lowS3_q;
		end
	end
	// rising edge of the filtered low clock
	assign lowEdge = lowLevel_d & ~lowLevel_q;

	// three sampling stages and the accepted level
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			lowS1_q <= 1'b0;
			lowS2_q <= 1'b0;
			lowS3_q <= 1'b0;
			lowLevel_q <= 1'b0;
		end else begin
			lowS1_q <= lowClock;
			lowS2_q <= lowS1_q;
			lowS3_q <= lowS2_q;
			lowLevel_q <= lowLevel_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// free-running prescalers

	logic [lfb_pkg::HIGH_PRE_W-1:0] highCnt_q, highCnt_d;
	logic [lfb_pkg::LOW_PRE_W-1:0] lowCnt_q, lowCnt_d;

	// never reloaded on a select change, so taps stay glitch free
	always_comb begin
		highCnt_d = highCnt_q + 1'b1;
		lowCnt_d = lowCnt_q;
		if (lowEdge) begin
			lowCnt_d = lowCnt_q + 1'b1;
		end
	end

	// prescaler state
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			highCnt_q <= '0;
			lowCnt_q <= '0;
		end else begin
			highCnt_q <= highCnt_d;
			lowCnt_q <= lowCnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// source and tap selection

	logic sysLow, frameLow, frameIdle, boostLow, boostIdle;
	logic [4:0] frameTap, boostTap;
	logic fastTick, boostTick;
	logic frameHit, boostHit;
	logic [16:0] lowWide;

	// low counter widened to the tap function's width
	assign lowWide = {8'h00, lowCnt_q};
	// system clock runs from the low clock
	assign sysLow = mode_q[lfb_pkg::POS_SYSTEM_CLOCK];

	// pick tap index and source for the frame and boost clocks
	always_comb begin
		frameLow = 1'b0;
		frameIdle = 1'b0;
		boostLow = 1'b0;
		boostIdle = 1'b0;
		case (ctrl_q.frameRateSelect)
			2'b00: frameTap = expo(lfb_pkg::FRAME_EXP_HIGH_0 - lfb_pkg::FAST_SHIFT);
			2'b01: frameTap = expo(lfb_pkg::FRAME_EXP_HIGH_1 - lfb_pkg::FAST_SHIFT);
			2'b10: frameTap = expo(lfb_pkg::FRAME_EXP_HIGH_2 - lfb_pkg::FAST_SHIFT);
			default: frameTap = expo(lfb_pkg::FRAME_EXP_HIGH_3 - lfb_pkg::FAST_SHIFT);
		endcase
		if ((mode_q != 2'b00) && !ctrl_q.frameRateSelect[1]) begin
			frameLow = 1'b1;
			if (ctrl_q.frameRateSelect[0]) begin
				frameTap = expo(lfb_pkg::FRAME_EXP_LOW_1 - lfb_pkg::FAST_SHIFT);
			end else begin
				frameTap = expo(lfb_pkg::FRAME_EXP_LOW_0 - lfb_pkg::FAST_SHIFT);
			end
		end else if (sysLow && ctrl_q.frameRateSelect[1]) begin
			frameIdle = 1'b1; // no high clock in slow modes
		end
		case (ctrl_q.boostFreqSelect)
			2'b00: boostTap = expo(lfb_pkg::BOOST_EXP_HIGH_0 - 1);
			2'b01: boostTap = expo(lfb_pkg::BOOST_EXP_HIGH_1 - 1);
			2'b10: boostTap = expo(lfb_pkg::BOOST_EXP_HIGH_2 - 1);
			default: boostTap = expo(lfb_pkg::BOOST_EXP_HIGH_3 - 1);
		endcase
		if (mode_q != 2'b00) begin
			boostLow = 1'b1;
			case (ctrl_q.boostFreqSelect)
				2'b00: boostTap = expo(lfb_pkg::BOOST_EXP_LOW_0 - 1);
				2'b01: boostTap = expo(lfb_pkg::BOOST_EXP_LOW_1 - 1);
				2'b10: boostTap = expo(lfb_pkg::BOOST_EXP_LOW_2 - 1);
				default: begin
					boostLow = 1'b0; // code 11 has no low option
					boostIdle = sysLow;
				end
			endcase
		end
	end

	// one-cycle ticks off the chosen tap
	assign frameHit = frameLow ? (lowEdge & tapHit(lowWide, frameTap)) : tapHit(highCnt_q, frameTap);
	assign boostHit = boostLow ? (lowEdge & tapHit(lowWide, boostTap)) : tapHit(highCnt_q, boostTap);
	// idle sources give no ticks at all
	assign fastTick = ~frameIdle & frameHit;
	assign boostTick = ~boostIdle & boostHit;

	////////////////////////////////////////////////////////////////////////
	// frame rate scaling by duty

	logic [1:0] fastCnt_q, fastCnt_d, baseCnt_q, baseCnt_d, frameDiv;
	logic frameTick_q, frameTick_d, baseTick_q, baseTick_d, boostClk_q, boostClk_d;

	// quarter and static keep base, third gives 4/3, half gives twice
	always_comb begin
		case (ctrl_q.duty)
			lfb_pkg::DUTY_THIRD: frameDiv = lfb_pkg::FRAME_DIV_THIRD;
			lfb_pkg::DUTY_HALF: frameDiv = lfb_pkg::FRAME_DIV_HALF;
			default: frameDiv = lfb_pkg::FRAME_DIV_QUARTER;
		endcase
		fastCnt_d = fastCnt_q;
		baseCnt_d = baseCnt_q;
		frameTick_d = 1'b0;
		baseTick_d = 1'b0;
		boostClk_d = boostClk_q;
		if (fastTick) begin
			baseCnt_d = baseCnt_q + 1'b1;
			baseTick_d = (baseCnt_q == lfb_pkg::FRAME_DIV_QUARTER);
			if (fastCnt_q >= frameDiv) begin
				fastCnt_d = 2'h0;
				frameTick_d = 1'b1;
			end else begin
				fastCnt_d = fastCnt_q + 1'b1;
			end
		end
		if (boostTick) begin
			boostClk_d = ~boostClk_q;
		end
	end

	// divider and output state
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			fastCnt_q <= 2'h0;
			baseCnt_q <= 2'h0;
			frameTick_q <= 1'b0;
			baseTick_q <= 1'b0;
			boostClk_q <= 1'b0;
		end else begin
			fastCnt_q <= fastCnt_d;
			baseCnt_q <= baseCnt_d;
			frameTick_q <= frameTick_d;
			baseTick_q <= baseTick_d;
			boostClk_q <= boostClk_d;
		end
	end

	// clock outputs straight from flip-flops
	assign frameTick = frameTick_q;
	assign baseTick = baseTick_q;
	assign boostClk = boostClk_q;

	////////////////////////////////////////////////////////////////////////
	// drive method and level source

	// duty decode into commons and bias
	always_comb begin
		case (ctrl_q.duty)
			lfb_pkg::DUTY_QUARTER: drive = '{commonCount: 3'h4, biasHalf: 1'b0, staticDrive: 1'b0};
			lfb_pkg::DUTY_THIRD: drive = '{commonCount: 3'h3, biasHalf: 1'b0, staticDrive: 1'b0};
			lfb_pkg::DUTY_HALF: drive = '{commonCount: 3'h2, biasHalf: 1'b1, staticDrive: 1'b0};
			default: drive = '{commonCount: 3'h1, biasHalf: 1'b0, staticDrive: 1'b1};
		endcase
	end

	// booster and resistor divider are exclusive
	assign boosterOn = ctrl_q.boosterEnable;
	assign dividerOn = ~ctrl_q.boosterEnable;
	assign displayOn = ctrl_q.displayEnable;

	// status shows clock levels and a booster bias mismatch
	always_comb begin
		statusWord = 8'h00;
		statusWord[lfb_pkg::POS_ST_FRAME_LEVEL] = fastCnt_q[1];
		statusWord[lfb_pkg::POS_ST_BOOST_LEVEL] = boostClk_q;
		statusWord[lfb_pkg::POS_ST_FRAME_LOW] = frameLow;
		statusWord[lfb_pkg::POS_ST_BIAS_FAULT] = ctrl_q.boosterEnable & ctrl_q.duty[1];
		statusWord[lfb_pkg::POS_ST_FRAME_IDLE] = frameIdle;
		statusWord[lfb_pkg::POS_ST_BOOST_IDLE] = boostIdle;
	end

endmodule : lfb_clock_select

// ==== bench/lfb_clock_select_monitor.sv ====
// lfb_clock_select_monitor: port assertions of the clock select block
// assumes: bound to lfb_clock_select, one clock domain on ref_clk
`timescale 1ns/1ns
module lfb_clock_select_monitor (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdata,
	input wire logic baseTick,
	input wire logic frameTick,
	input wire logic boostClk,
	input wire logic boosterOn,
	input wire logic dividerOn,
	input wire logic displayOn,
	input wire lfb_pkg::lfb_drive_t drive
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////
	// level source and control field decode
	property p_div; boosterOn != dividerOn; endproperty
	a_div: assert property (p_div) else $error("level source not exclusive");
	property p_bst; regWrite && regAddr == 8'h28 |=> boosterOn == $past(regWdata[6]); endproperty
	a_bst: assert property (p_bst) else $error("booster bit not applied");
	property p_drv;
		regWrite && regAddr == 8'h28 |=> drive == {3'(4 - $past(regWdata[3:2])),
			$past(regWdata[3:2]) == 2'b10, $past(regWdata[3:2]) == 2'b11};
	endproperty
	a_drv: assert property (p_drv) else $error("duty decode wrong");
	property p_rdb; regRead && regAddr == 8'h28 |=> regRdata[7:6] == {displayOn, boosterOn}; endproperty
	a_rdb: assert property (p_rdb) else $error("control readback wrong");
	property p_idle; !regRead |=> regRdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data outside read slot");
	////////////////////////////////////////////////////////////
	// tick spacing and boost clock without runts
	property p_base; baseTick |=> !baseTick [*8]; endproperty
	a_base: assert property (p_base) else $error("base ticks too close");
	property p_frm; frameTick |=> !frameTick [*8]; endproperty
	a_frm: assert property (p_frm) else $error("frame ticks too close");
	property p_bhi; $rose(boostClk) |-> boostClk [*4]; endproperty
	a_bhi: assert property (p_bhi) else $error("boost high runt");
	property p_blo; $fell(boostClk) |-> !boostClk [*4]; endproperty
	a_blo: assert property (p_blo) else $error("boost low runt");
	c_frm: cover property (frameTick);
	c_bst: cover property ($rose(boostClk));
	c_rd: cover property (regRead && regAddr == 8'h28);
endmodule : lfb_clock_select_monitor

// ==== bench/lfb_lcd_panel.sv ====
// lfb_lcd_panel: panel side, counts frames and watches bias
// assumes: frameTick and drive come straight from the block
`timescale 1ns/1ns
module lfb_lcd_panel (
	input wire logic ref_clk,
	input wire logic frameTick,
	input wire logic boosterOn,
	input wire lfb_pkg::lfb_drive_t drive,
	output int frameCount,
	output logic biasFault
);
	initial frameCount = 0;
	// frames scanned so far
	always @(posedge ref_clk) frameCount <= frameCount + (frameTick ? 1 : 0);
	// booster feeds one-third bias only
	assign biasFault = boosterOn && (drive.biasHalf || drive.staticDrive);
endmodule : lfb_lcd_panel

// ==== bench/lfb_clock_select_tb.sv ====
// lfb_clock_select_tb: register, tick and boost clock checks
// assumes: 125 MHz ref_clk, lowClock made here at one eighth of it
`timescale 1ns/1ns
module lfb_clock_select_tb;
	localparam logic [7:0] AC = lfb_pkg::OFS_LCD_CONTROL;
	localparam logic [7:0] AM = lfb_pkg::OFS_CLOCK_MODE;
	logic ref_clk = 0, sys_rst = 1, lowClock = 0, regWrite = 0, regRead = 0;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
	logic baseTick, frameTick, boostClk, boosterOn, dividerOn, displayOn, biasFault;
	lfb_pkg::lfb_drive_t drive;
	int bad_count = 0, total_checks = 0, frameCount;
	lfb_clock_select uut (.ref_clk, .sys_rst, .lowClock, .regAddr, .regWdata, .regWrite, .regRead,
		.regRdata, .baseTick, .frameTick, .boostClk, .boosterOn, .dividerOn, .displayOn, .drive);
	lfb_lcd_panel panel (.ref_clk, .frameTick, .boosterOn, .drive, .frameCount, .biasFault);
	initial forever #4 ref_clk = ~ref_clk;
	// low clock, eight high cycles a period
	initial forever begin
		repeat (4) @(posedge ref_clk);
		lowClock <= ~lowClock;
	end
	////////////////////////////////////////////////////////////
	task chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask : chk
	task results;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1;
		@(posedge ref_clk);
		regWrite <= 0;
		#1;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= 1;
		@(posedge ref_clk);
		regRead <= 0;
		#1 chk(regRdata === e, "read data");
	endtask : rd
	// status read with the clock level bits masked out
	task rds(input logic [7:0] e);
		@(posedge ref_clk);
		regAddr <= lfb_pkg::OFS_STATUS;
		regRead <= 1;
		@(posedge ref_clk);
		regRead <= 0;
		#1 chk((regRdata & 8'h3C) === e, "status flags");
	endtask : rds
	// no frame tick and a still boost clock for n cycles
	task quiet(input int n);
		int t;
		logic b;
		t = 0;
		b = boostClk;
		repeat (n) begin
			@(posedge ref_clk);
			#1 t = t + ((frameTick === 1'b0 && boostClk === b) ? 0 : 1);
		end
		chk(t == 0, "idle clocks moved");
	endtask : quiet
	// spacing in cycles between pulses, after skipping some
	task gap(input int sel, input int skip, input int exp);
		int n, k, last;
		logic p, h;
		k = 0;
		last = 0;
		p = boostClk;
		for (n = 0; n < 40000 && k < skip + 2; n++) begin
			@(posedge ref_clk);
			#1 h = sel == 0 ? baseTick : sel == 1 ? frameTick : boostClk && !p;
			p = boostClk;
			if (h === 1'b1) begin
				k++;
				if (k == skip + 2) chk(n - last == exp, "pulse spacing");
				last = n;
			end
		end
		if (k < skip + 2) begin
			bad_count++;
			$display("FAIL %0t no pulse", $time);
			results;
		end
	endtask : gap
	////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 0;
		#1 chk(dividerOn && !boosterOn && !displayOn && drive === 5'b10000, "reset levels");
		rd(AC, 8'h00);
		rd(AM, 8'h00);
		wr(8'h3C, 8'hFF);
		wr(lfb_pkg::OFS_STATUS, 8'hFF);
		rd(8'h3C, 8'h00);
		rd(AC, 8'h00);
		for (int d = 0; d < 4; d++) begin
			wr(AC, 8'(d * 4));
			chk(drive === {3'(4 - d), d == 2, d == 3}, "duty decode");
		end
		wr(AC, 8'hC3);
		chk(boosterOn && !dividerOn && displayOn, "booster select");
		rd(AC, 8'hC3);
		gap(0, 0, 8192);
		gap(2, 0, 8192);
		wr(AC, 8'h07);
		gap(1, 1, 6144);
		for (int b = 1; b < 4; b++) begin
			wr(AC, 8'(b * 16 + 3));
			gap(2, 1, 1 << (12 - b));
		end
		wr(AM, 8'h01);
		for (int d = 0; d < 4; d++) begin
			wr(AC, 8'(d * 4 + 1));
			gap(1, 1, d == 1 ? 1536 : d == 2 ? 1024 : 2048);
		end
		gap(0, 0, 2048);
		for (int b = 0; b < 3; b++) begin
			wr(AC, 8'(b * 16));
			gap(2, 1, 8 << (b == 0 ? 5 : 4 - b));
		end
		gap(0, 0, 4096);
		wr(AC, 8'h30);
		gap(2, 1, 512);
		wr(AM, 8'h02);
		wr(AC, 8'h7B);
		chk(biasFault === 1'b1, "bias fault not seen");
		rds(8'h38);
		quiet(4200);
		@(posedge ref_clk);
		sys_rst <= 1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 0;
		#1 chk(!boosterOn && dividerOn && biasFault === 1'b0 && frameCount > 0, "after reset");
		rd(AM, 8'h00);
		results;
	end
endmodule : lfb_clock_select_tb
bind lfb_clock_select lfb_clock_select_monitor mon (.ref_clk, .sys_rst, .regAddr, .regWdata, .regWrite,
	.regRead, .regRdata, .baseTick, .frameTick, .boostClk, .boosterOn, .dividerOn, .displayOn, .drive);
